// ---- src/cbsu_pkg.sv ----
// Package with constants and types of the conditional branch and skip unit
// How it works
// - Set I/O bit skips next instruction, PC+2/3
// - Chosen flag set branches to PC+k+1
// - Chosen flag clear branches to PC+k+1
// - Null flag set branches to PC+k+1
// - Null flag clear branches to PC+k+1
// - Carry set branches to PC+k+1
package cbsu_pkg;
  // Operation codes presented with each request
  typedef enum logic [2:0] {
    CBSU_OP_SKIP_IO_SET    = 3'h0,  // Skip if I/O bit set
    CBSU_OP_BR_FLAG_SET    = 3'h1,  // branch_on_chosen_flag_set
    CBSU_OP_BR_FLAG_CLR    = 3'h2,  // branch_on_chosen_flag_cleared
    CBSU_OP_BR_EQUAL       = 3'h3,  // branch_if_equal_op
    CBSU_OP_BR_NOT_EQUAL   = 3'h4,  // branch_if_not_equal_op
    CBSU_OP_BR_CARRY_SET   = 3'h5   // branch_if_borrow_out_set
  } cbsu_op_type;
  // Unit states, Gray along idle -> second cycle
  typedef enum logic [0:0] {
    CBSU_ST_IDLE  = 1'h0,           // Accepting requests
    CBSU_ST_SECND = 1'h1            // Second cycle of a taken branch or skip
  } cbsu_state_type;
  localparam int unsigned CBSU_FLAG_CARRY = 0;   // Carry bit position in status flags
  localparam int unsigned CBSU_FLAG_NULL  = 1;   // Result-null bit position
  localparam int unsigned CBSU_SKIP_SHORT = 2;   // Skip over a one-word instruction
  localparam int unsigned CBSU_SKIP_LONG  = 3;   // Skip over a two-word instruction
  localparam int unsigned CBSU_PC_RESET   = 0;   // Program counter after reset
endpackage : cbsu_pkg

// ---- src/cbsu_if.sv ----
// Interface carrying the decision between condition evaluator and the top
`timescale 1ns/1ps
interface cbsu_if #(
  parameter int PC_W = 16
);
  logic            taken;   // Condition holds
  logic [PC_W-1:0] target;  // Program counter when condition holds
  modport eval (output taken, output target);
  modport top  (input taken, input target);
endinterface : cbsu_if

// ---- src/cbsu_eval.sv ----
// Combinational condition evaluator and target calculator
`timescale 1ns/1ps
module cbsu_eval #(
  parameter int PC_W = 16
) (
  input  wire logic [2:0]      i_op,        // Operation code
  input  wire logic [PC_W-1:0] i_pc,        // Current program counter
  input  wire logic [6:0]      i_offset,    // Signed branch offset
  input  wire logic [2:0]      i_sel,       // Flag or bit select
  input  wire logic [7:0]      i_flags,     // status_flag_register contents
  input  wire logic [7:0]      i_io_bits,   // Selected I/O register value
  input  wire logic            i_skip_long, // Skipped instruction is two words
  cbsu_if.eval                 dec          // Decision out
);
  wire logic            chosen_flag = i_flags[i_sel];   // Flag picked by select
  wire logic            io_bit      = i_io_bits[i_sel]; // I/O bit picked by select
  wire logic [PC_W-1:0] off_ext     = PC_W'($signed(i_offset));
  wire logic [PC_W-1:0] br_target   = i_pc + off_ext + PC_W'(1);
  wire logic [PC_W-1:0] skip_target = i_pc + PC_W'(i_skip_long ?
                                      cbsu_pkg::CBSU_SKIP_LONG :
                                      cbsu_pkg::CBSU_SKIP_SHORT);
  logic cond;
  // Condition per operation
  always_comb begin
    unique case (i_op)
      3'h0:    cond = io_bit;
      3'h1:    cond = chosen_flag;
      3'h2:    cond = ~chosen_flag;
      3'h3:    cond = i_flags[cbsu_pkg::CBSU_FLAG_NULL];
      3'h4:    cond = ~i_flags[cbsu_pkg::CBSU_FLAG_NULL];
      3'h5:    cond = i_flags[cbsu_pkg::CBSU_FLAG_CARRY];
      default: cond = 1'b0;                                     // Illegal op never taken
    endcase
  end
  assign dec.taken  = cond;
  assign dec.target = (i_op == 3'h0) ? skip_target : br_target;
endmodule : cbsu_eval

// ---- src/cbsu_top.sv ----
// Top of the conditional branch and skip unit
`timescale 1ns/1ps
module cbsu_top #(
  parameter int PC_W = 16
) (
  input  wire logic            i_clock,      // Core clock
  input  wire logic            i_rst_b,      // Synchronous reset, active low
  input  wire logic            i_valid,      // Request pulse, one cycle
  input  wire logic [2:0]      i_op,         // Operation code
  input  wire logic [PC_W-1:0] i_pc,         // Program counter of the instruction
  input  wire logic [6:0]      i_offset,     // Signed branch offset
  input  wire logic [2:0]      i_sel,        // Flag or bit select
  input  wire logic [7:0]      i_flags,      // status_flag_register
  input  wire logic [7:0]      i_io_bits,    // Selected I/O register
  input  wire logic            i_skip_long,  // Next instruction is two words
  output logic                 o_busy,       // Second cycle in progress
  output logic                 o_done,       // Decision complete pulse
  output logic                 o_taken,      // Branch or skip was taken
  output logic [PC_W-1:0]      o_next_pc,    // Next program counter
  output logic [7:0]           o_flags       // Flags passed through unchanged
);

  // Overview
  // A request is accepted on a rising edge with i_valid high while the
  // unit is idle. The evaluator decides at once whether the condition of
  // the presented operation holds and what the jump target would be.
  // An untaken operation answers one cycle later with the next word.
  // A taken branch or skip spends one busy cycle and answers in the
  // cycle after, so the fetch side sees two cycles as it would in the
  // core. Requests seen while busy are dropped without any indication.
  // The status flags are only ever copied, one cycle late, never changed.

  // Refuse counter widths that the target arithmetic cannot serve
  if (PC_W < 8 || PC_W > 32) begin : g_bad_pc_w
    $error("PC_W out of range");
  end

  // Next word after an instruction; wraps at the counter width
  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc);
    pc_step = pc + PC_W'(1);
  endfunction : pc_step

  // Value every program counter register takes in reset
  function automatic logic [PC_W-1:0] pc_reset_value();
    pc_reset_value = PC_W'(cbsu_pkg::CBSU_PC_RESET);
  endfunction : pc_reset_value

  // Decision carrier between the evaluator and this level
  cbsu_if #(.PC_W(PC_W)) dec ();

  // Control state
  cbsu_pkg::cbsu_state_type state_r;       // Idle or second cycle
  cbsu_pkg::cbsu_state_type state_nxt;     // Next control state

  // Held target for the second cycle of a taken operation
  logic [PC_W-1:0]          hold_pc_r;     // Target captured at acceptance
  logic [PC_W-1:0]          hold_pc_nxt;   // Next held target

  // Output registers, one per output port
  logic                     busy_r;        // Second cycle in progress
  logic                     busy_nxt;      // Next busy level
  logic                     done_r;        // One-cycle completion pulse
  logic                     done_nxt;      // Next completion pulse
  logic                     taken_r;       // Last decision was taken
  logic                     taken_nxt;     // Next taken level
  logic [PC_W-1:0]          next_pc_r;     // Program counter handed on
  logic [PC_W-1:0]          next_pc_nxt;   // Next program counter value
  logic [7:0]               flags_r;       // Copy of the status flags
  logic [7:0]               flags_nxt;     // Next copy of the flags

  // Evaluator instance: condition and target, purely combinational
  cbsu_eval #(.PC_W(PC_W)) u_eval (
    .i_op        (i_op),
    .i_pc        (i_pc),
    .i_offset    (i_offset),
    .i_sel       (i_sel),
    .i_flags     (i_flags),
    .i_io_bits   (i_io_bits),
    .i_skip_long (i_skip_long),
    .dec         (dec)
  );

  // Acceptance and the two ways a decision can go
  wire logic            is_idle  = (state_r == cbsu_pkg::CBSU_ST_IDLE);
  wire logic            accept   = i_valid && is_idle;     // Busy drops requests
  wire logic            go_long  = accept && dec.taken;    // Taken needs a second cycle
  wire logic            go_short = accept && !dec.taken;   // Untaken finishes now
  wire logic [PC_W-1:0] fall_pc  = pc_step(i_pc);          // Fall-through word

  // Next values of the control state and the output registers
  always_comb begin
    // Defaults: hold everything, no pulse, flags follow the input
    state_nxt   = state_r;
    hold_pc_nxt = hold_pc_r;
    busy_nxt    = busy_r;
    done_nxt    = 1'b0;
    taken_nxt   = taken_r;
    next_pc_nxt = next_pc_r;
    flags_nxt   = i_flags;
    unique case (state_r)
      // Idle: decide on an accepted request
      cbsu_pkg::CBSU_ST_IDLE: begin
        if (go_long) begin
          // Taken: keep the target and spend one busy cycle
          state_nxt   = cbsu_pkg::CBSU_ST_SECND;
          hold_pc_nxt = dec.target;
          busy_nxt    = 1'b1;
        end else if (go_short) begin
          // Untaken: answer at once with the next word
          done_nxt    = 1'b1;
          taken_nxt   = 1'b0;
          next_pc_nxt = fall_pc;
        end
      end
      // Second cycle: hand on the held target
      cbsu_pkg::CBSU_ST_SECND: begin
        state_nxt   = cbsu_pkg::CBSU_ST_IDLE;
        busy_nxt    = 1'b0;
        done_nxt    = 1'b1;
        taken_nxt   = 1'b1;
        next_pc_nxt = hold_pc_r;
      end
    endcase
  end

  // Control state register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_r <= cbsu_pkg::CBSU_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Held target register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      hold_pc_r <= pc_reset_value();
    end else begin
      hold_pc_r <= hold_pc_nxt;
    end
  end

  // Busy register; high only in the second cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // Completion pulse register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  // Taken register; holds until the next completion
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      taken_r <= 1'b0;
    end else begin
      taken_r <= taken_nxt;
    end
  end

  // Program counter register; holds until the next completion
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      next_pc_r <= pc_reset_value();
    end else begin
      next_pc_r <= next_pc_nxt;
    end
  end

  // Flag copy register; the flags are never altered on the way
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Outputs straight from the registers above
  assign o_busy    = busy_r;
  assign o_done    = done_r;
  assign o_taken   = taken_r;
  assign o_next_pc = next_pc_r;
  assign o_flags   = flags_r;

  // Rule marks for the conditions decided in the evaluator:
  // chosen flag set chosen flag clear null set
  // null clear carry set each target is pc plus offset plus one.
  // Skip targets step over one or two words.
  // Illegal operation codes are never taken and fall through in one cycle.
  // A request during the busy cycle is lost; the fetch side must wait
  // for the completion pulse before presenting the next instruction.

endmodule : cbsu_top

// ---- verif/cbsu_top_monitor.sv ----
// Checker of timing, targets and flag pass-through of the unit
`timescale 1ns/1ps
module cbsu_top_monitor #(parameter int PC_W = 16) (
  input wire logic            i_clock, i_rst_b, i_valid, i_skip_long,
  input wire logic [2:0]      i_op, i_sel,
  input wire logic [6:0]      i_offset,
  input wire logic [7:0]      i_flags, i_io_bits, o_flags,
  input wire logic [PC_W-1:0] i_pc, o_next_pc,
  input wire logic            o_busy, o_done, o_taken
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire req = i_valid && !o_busy;  // Request accepted this edge
  // Condition of each operation; unused codes never hold
  wire cnd = (i_op == 3'h0) ? i_io_bits[i_sel] : (i_op == 3'h1) ? i_flags[i_sel] :
    (i_op == 3'h2) ? !i_flags[i_sel] : (i_op == 3'h3) ? i_flags[1] :
    (i_op == 3'h4) ? !i_flags[1] : (i_op == 3'h5) && i_flags[0];
  // Target of a taken branch, wrapping with the counter width
  wire [PC_W-1:0] tgt = i_pc + PC_W'($signed(i_offset)) + 1'b1;
  wire [PC_W-1:0] skp = i_pc + (i_skip_long ? 3 : 2);  // Skip target
  taken_busy_a: assert property (req && cnd |=> o_busy ##1 o_done && o_taken && !o_busy)
    else $error("taken timing");
  taken_pc_a: assert property (req && cnd && i_op != 3'h0 |=> ##1 o_next_pc == $past(tgt, 2))
    else $error("branch target");
  skip_pc_a: assert property (req && cnd && i_op == 3'h0 |=> ##1 o_next_pc == $past(skp, 2))
    else $error("skip target");
  fall_done_a: assert property (req && !cnd |=> o_done && !o_taken && !o_busy)
    else $error("fall timing");
  fall_pc_a: assert property (req && !cnd |=> o_next_pc == $past(i_pc) + 1'b1)
    else $error("fall target");
  flags_pass_a: assert property ($past(i_rst_b) |-> o_flags == $past(i_flags))
    else $error("flags changed");
  busy_once_a: assert property (o_busy |=> !o_busy) else $error("busy too long");
  done_cause_a: assert property (o_done |-> $past(req) || $past(o_busy))
    else $error("stray done");
endmodule : cbsu_top_monitor
bind cbsu_top cbsu_top_monitor #(.PC_W(PC_W)) u_mon (.*);

// ---- verif/cbsu_top_test.sv ----
// Self-checking bench of the conditional branch and skip unit
`timescale 1ns/1ps
module cbsu_top_test;
  logic        i_clock = 1'h0, i_rst_b = 1'h0, i_valid = 1'h0, i_skip_long = 1'h0;
  logic [2:0]  i_op = 3'h0, i_sel = 3'h0;
  logic [6:0]  i_offset = 7'h00;
  logic [7:0]  i_flags = 8'h00, i_io_bits = 8'h00, o_flags;
  logic [15:0] i_pc = 16'h0000, o_next_pc;
  logic        o_busy, o_done, o_taken;
  int          mismatches = 0, num_checks = 0;  // Failure and comparison counts
  cbsu_top u_dut (.*);
  initial begin forever #5 i_clock = ~i_clock; end
  // Compare one value and report a difference
  task automatic chk(input logic [31:0] a, input logic [31:0] b);
    num_checks++;
    if (a !== b) begin mismatches++; $display("CHECK FAILED %0t %h %h", $time, a, b); end
  endtask : chk
  // One request; with l set a taken one repeats i_valid into its busy cycle
  task automatic go(input logic [2:0] op, input logic [15:0] p, input logic [6:0] k,
      input logic [2:0] s, input logic [7:0] d, input logic l, input logic [15:0] e);
    logic t;
    t = e !== p + 16'h0001;  // Taken unless the target is the next word
    @(posedge i_clock) #1;
    {i_op, i_pc, i_offset, i_sel, i_skip_long} = {op, p, k, s, l};
    {i_valid, i_flags, i_io_bits} = {1'h1, d, d};
    @(posedge i_clock) #1;
    i_valid = l & t;
    chk(o_busy, t);
    if (t) @(posedge i_clock) #1;
    i_valid = 1'h0;
    chk({o_done, o_taken, o_busy, o_flags}, {1'h1, t, 1'h0, d});
    chk(o_next_pc, e);
    @(posedge i_clock) #1;
    chk({o_done, o_next_pc}, {1'h0, e});  // Single pulse, target holds
  endtask : go
  task automatic t_skip;
    go(3'h0, 16'h0010, 7'h00, 3'h3, 8'h08, 1'h0, 16'h0012);
    go(3'h0, 16'h0010, 7'h00, 3'h7, 8'h80, 1'h1, 16'h0013);
    go(3'h0, 16'h0010, 7'h00, 3'h3, 8'hF7, 1'h1, 16'h0011);
  endtask : t_skip
  task automatic t_flag;
    go(3'h1, 16'h0100, 7'h7F, 3'h5, 8'h20, 1'h1, 16'h0100);
    go(3'h2, 16'h0100, 7'h3F, 3'h5, 8'h20, 1'h0, 16'h0101);
    go(3'h2, 16'h0100, 7'h3F, 3'h4, 8'h20, 1'h0, 16'h0140);
  endtask : t_flag
  task automatic t_zc;
    go(3'h3, 16'h0000, 7'h40, 3'h0, 8'h02, 1'h0, 16'hFFC1);
    go(3'h4, 16'h0000, 7'h40, 3'h0, 8'h02, 1'h0, 16'h0001);
    go(3'h4, 16'h0200, 7'h05, 3'h0, 8'hFD, 1'h0, 16'h0206);
    go(3'h5, 16'h0300, 7'h10, 3'h0, 8'h01, 1'h0, 16'h0311);
    go(3'h5, 16'h0300, 7'h10, 3'h0, 8'hFE, 1'h0, 16'h0301);
  endtask : t_zc
  // Unused operation codes never branch
  task automatic t_odd;
    go(3'h6, 16'h0400, 7'h05, 3'h0, 8'hFF, 1'h0, 16'h0401);
    go(3'h7, 16'h0400, 7'h05, 3'h0, 8'hFF, 1'h0, 16'h0401);
  endtask : t_odd
  // Reset in mid-run clears every output
  task automatic t_reset;
    @(posedge i_clock) #1;
    i_rst_b = 1'h0;
    @(posedge i_clock) #1;
    chk({o_busy, o_done, o_taken, o_next_pc, o_flags}, 32'h0);
    i_rst_b = 1'h1;
  endtask : t_reset
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin #20000; mismatches++; test_done; end
  initial begin
    repeat (6) @(posedge i_clock);
    #1 i_rst_b = 1'h1;
    t_skip;
    t_flag;
    t_zc;
    t_reset;
    t_odd;
    test_done;
  end
endmodule : cbsu_top_test
